// ===== logic/imf_pkg.sv
// Constants and carrier types for the interprocessor mailbox flag block.
// Assumes a single 40 MHz clock and a plain register port per core side.
`default_nettype none
package imf_pkg;
  localparam int unsigned ADDR_W = 6;
  localparam int unsigned DATA_W = 16;
  localparam logic [5:0] OFF_H2S_MBOX1_WORD_B  = 6'h04;
  localparam logic [5:0] OFF_S2H_MBOX1_WORD_B  = 6'h0c;
  localparam logic [5:0] OFF_S2H_MBOX2_WORD_B  = 6'h14;
  localparam logic [5:0] OFF_H2S_MBOX1_PENDING = 6'h18;
  localparam logic [5:0] OFF_S2H_MBOX1_PENDING = 6'h1c;
  localparam logic [5:0] OFF_S2H_MBOX2_PENDING = 6'h20;
  localparam logic [5:0] OFF_H2S_MBOX2_WORD_A  = 6'h24;
  localparam logic [5:0] OFF_H2S_MBOX2_WORD_B  = 6'h28;
  localparam logic [5:0] OFF_H2S_MBOX2_PENDING = 6'h2c;
  localparam logic [5:0] OFF_IRQ_STATUS        = 6'h30;
  localparam logic [5:0] OFF_IRQ_MASK          = 6'h34;
  localparam int unsigned PEND_BIT = 0;
  localparam logic [15:0] WORD_RESET = 16'h0000;
  localparam logic [3:0] MASK_RESET = 4'h0;
  // Event bit order in status and mask
  localparam int unsigned EV_H2S1 = 0;
  localparam int unsigned EV_H2S2 = 1;
  localparam int unsigned EV_S2H1 = 2;
  localparam int unsigned EV_S2H2 = 3;
  localparam int unsigned N_EV    = 4;
  typedef struct packed {
    logic [5:0]  addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
  } imf_req_s;
endpackage : imf_pkg
`default_nettype wire

// ===== logic/imf_mailbox_flags.sv
// Pending flags of both mailbox directions and host-to-signal mailbox 2 data.
// Assumes both register ports are synchronous to mclk; no wait states.
`default_nettype none
module imf_mailbox_flags
  import imf_pkg::*;
#(
  parameter int unsigned DATA_W_P = DATA_W,
  parameter int unsigned ADDR_W_P = ADDR_W,
  parameter int unsigned N_EV_P   = N_EV
)
(
  input  wire logic              mclk,
  input  wire logic              reset,
  input  wire imf_pkg::imf_req_s host_req,
  output logic [15:0]            host_rdata,
  input  wire imf_pkg::imf_req_s sig_req,
  output logic [15:0]            sig_rdata,
  input  wire logic              h2s_mbox1_word_b_wr,
  input  wire logic              h2s_mbox1_word_b_rd,
  input  wire logic              s2h_mbox1_word_b_wr,
  input  wire logic              s2h_mbox1_word_b_rd,
  input  wire logic              s2h_mbox2_word_b_wr,
  input  wire logic              s2h_mbox2_word_b_rd,
  output logic                   host_to_sig_mbox1_irq,
  output logic                   host_to_sig_mbox2_irq,
  output logic                   sig_to_host_mbox1_irq,
  output logic                   sig_to_host_mbox2_irq,
  output logic                   irq
);
  import imf_pkg::*;

  // Refuse sizes the request carrier cannot serve
  if (DATA_W_P != DATA_W) begin : g_chk_data_w
    $error("imf_mailbox_flags: DATA_W_P must equal the carrier data width");
  end
  if (ADDR_W_P != ADDR_W) begin : g_chk_addr_w
    $error("imf_mailbox_flags: ADDR_W_P must equal the carrier address width");
  end
  if (N_EV_P != N_EV) begin : g_chk_n_ev
    $error("imf_mailbox_flags: N_EV_P must equal the number of flag events");
  end

  // Pending flags per direction and mailbox
  logic                h2s1_q;
  logic                h2s2_q;
  logic                s2h1_q;
  logic                s2h2_q;

  // Mailbox 2 data words
  logic [DATA_W_P-1:0] word_a_q;
  logic [DATA_W_P-1:0] word_b_q;

  // Event status, mask and level output
  logic [N_EV_P-1:0]   ev;
  logic [N_EV_P-1:0]   status_q;
  logic [N_EV_P-1:0]   status_d;
  logic [N_EV_P-1:0]   mask_q;
  logic [N_EV_P-1:0]   mask_d;
  logic                irq_d;

  // Read data next values
  logic [DATA_W_P-1:0] host_rdata_d;
  logic [DATA_W_P-1:0] sig_rdata_d;

  // Host side register hits
  logic                h_hit_h2s1_pend;
  logic                h_hit_h2s2_pend;
  logic                h_hit_word_a;
  logic                h_hit_word_b;
  logic                h_hit_stat;
  logic                h_hit_mask;

  // Signal core register hits
  logic                s_hit_s2h1_pend;
  logic                s_hit_s2h2_pend;
  logic                s_hit_word_a;
  logic                s_hit_word_b;

  // Strobes qualified by address
  logic                h_wr_a2;
  logic                h_wr_b2;
  logic                h_wr_mask;
  logic                s_rd_b2;
  logic                h_rd_stat;

  // Host address decode
  assign h_hit_h2s1_pend = host_req.addr == OFF_H2S_MBOX1_PENDING;
  assign h_hit_h2s2_pend = host_req.addr == OFF_H2S_MBOX2_PENDING;
  assign h_hit_word_a    = host_req.addr == OFF_H2S_MBOX2_WORD_A;
  assign h_hit_word_b    = host_req.addr == OFF_H2S_MBOX2_WORD_B;
  assign h_hit_stat      = host_req.addr == OFF_IRQ_STATUS;
  assign h_hit_mask      = host_req.addr == OFF_IRQ_MASK;

  // Signal core address decode
  assign s_hit_s2h1_pend = sig_req.addr == OFF_S2H_MBOX1_PENDING;
  assign s_hit_s2h2_pend = sig_req.addr == OFF_S2H_MBOX2_PENDING;
  assign s_hit_word_a    = sig_req.addr == OFF_H2S_MBOX2_WORD_A;
  assign s_hit_word_b    = sig_req.addr == OFF_H2S_MBOX2_WORD_B;

  // Strobes; signal core writes are never qualified
  assign h_wr_a2   = host_req.wr && h_hit_word_a;
  assign h_wr_b2   = host_req.wr && h_hit_word_b;
  assign h_wr_mask = host_req.wr && h_hit_mask;
  assign s_rd_b2   = sig_req.rd && s_hit_word_b;
  assign h_rd_stat = host_req.rd && h_hit_stat;

  // Mailbox 2 word a, host write only
  always_ff @(posedge mclk) begin
    if (reset) begin
      word_a_q <= WORD_RESET;
    end else if (h_wr_a2) begin
      word_a_q <= host_req.wdata;
    end
  end

  // Mailbox 2 word b, host write only
  always_ff @(posedge mclk) begin
    if (reset) begin
      word_b_q <= WORD_RESET;
    end else if (h_wr_b2) begin
      word_b_q <= host_req.wdata;
    end
  end

  // Host-to-core mailbox 1 flag; set wins
  always_ff @(posedge mclk) begin
    if (reset) begin
      h2s1_q <= 1'b0;
    end else if (h2s_mbox1_word_b_wr) begin
      h2s1_q <= 1'b1;
    end else if (h2s_mbox1_word_b_rd) begin
      h2s1_q <= 1'b0;
    end
  end

  // Host-to-core mailbox 2 flag; set wins
  always_ff @(posedge mclk) begin
    if (reset) begin
      h2s2_q <= 1'b0;
    end else if (h_wr_b2) begin
      h2s2_q <= 1'b1;
    end else if (s_rd_b2) begin
      h2s2_q <= 1'b0;
    end
  end

  // Core-to-host mailbox 1 flag; set wins
  always_ff @(posedge mclk) begin
    if (reset) begin
      s2h1_q <= 1'b0;
    end else if (s2h_mbox1_word_b_wr) begin
      s2h1_q <= 1'b1;
    end else if (s2h_mbox1_word_b_rd) begin
      s2h1_q <= 1'b0;
    end
  end

  // Core-to-host mailbox 2 flag; set wins
  always_ff @(posedge mclk) begin
    if (reset) begin
      s2h2_q <= 1'b0;
    end else if (s2h_mbox2_word_b_wr) begin
      s2h2_q <= 1'b1;
    end else if (s2h_mbox2_word_b_rd) begin
      s2h2_q <= 1'b0;
    end
  end

  // Interrupt lines follow the flags
  assign host_to_sig_mbox1_irq = h2s1_q;
  assign host_to_sig_mbox2_irq = h2s2_q;
  assign sig_to_host_mbox1_irq = s2h1_q;
  assign sig_to_host_mbox2_irq = s2h2_q;

  // Events that set status bits
  always_comb begin
    ev          = '0;
    ev[EV_H2S1] = h2s_mbox1_word_b_wr;
    ev[EV_H2S2] = h_wr_b2;
    ev[EV_S2H1] = s2h_mbox1_word_b_wr;
    ev[EV_S2H2] = s2h_mbox2_word_b_wr;
  end

  // Status next value; events beside a read stay
  always_comb begin
    if (h_rd_stat) begin
      status_d = ev;
    end else begin
      status_d = status_q | ev;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      status_q <= '0;
    end else begin
      status_q <= status_d;
    end
  end

  // Mask next value
  always_comb begin
    if (h_wr_mask) begin
      mask_d = host_req.wdata[N_EV_P-1:0];
    end else begin
      mask_d = mask_q;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      mask_q <= MASK_RESET;
    end else begin
      mask_q <= mask_d;
    end
  end

  // Level interrupt tracks status and mask
  always_comb begin
    irq_d = |(status_d & mask_d);
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      irq <= 1'b0;
    end else begin
      irq <= irq_d;
    end
  end

  // Host side read mux
  always_comb begin
    host_rdata_d = '0;
    if (host_req.rd) begin
      if (h_hit_h2s1_pend) begin
        host_rdata_d[PEND_BIT] = h2s1_q;
      end else if (h_hit_h2s2_pend) begin
        host_rdata_d[PEND_BIT] = h2s2_q;
      end else if (h_hit_word_a) begin
        host_rdata_d = word_a_q;
      end else if (h_hit_word_b) begin
        host_rdata_d = word_b_q;
      end else if (h_hit_stat) begin
        host_rdata_d[N_EV_P-1:0] = status_q;
      end else if (h_hit_mask) begin
        host_rdata_d[N_EV_P-1:0] = mask_q;
      end
    end
  end

  // Host read data stands one cycle
  always_ff @(posedge mclk) begin
    if (reset) begin
      host_rdata <= WORD_RESET;
    end else begin
      host_rdata <= host_rdata_d;
    end
  end

  // Signal core read mux; words read-only here
  always_comb begin
    sig_rdata_d = '0;
    if (sig_req.rd) begin
      if (s_hit_s2h1_pend) begin
        sig_rdata_d[PEND_BIT] = s2h1_q;
      end else if (s_hit_s2h2_pend) begin
        sig_rdata_d[PEND_BIT] = s2h2_q;
      end else if (s_hit_word_a) begin
        sig_rdata_d = word_a_q;
      end else if (s_hit_word_b) begin
        sig_rdata_d = word_b_q;
      end
    end
  end

  // Core read data stands one cycle
  always_ff @(posedge mclk) begin
    if (reset) begin
      sig_rdata <= WORD_RESET;
    end else begin
      sig_rdata <= sig_rdata_d;
    end
  end

  // Host flag registers never reach the core port
  // Core flag registers never reach the host port
  // Unmapped reads return zero on both ports
endmodule : imf_mailbox_flags
`default_nettype wire

// ===== sim/imf_mailbox_flags_sva.sv
// Checker for the mailbox flag block
// Sees only the top ports; one clock, sync reset
`default_nettype none
module imf_mailbox_flags_sva
  import imf_pkg::*;
(
  input wire logic              mclk,
  input wire logic              reset,
  input wire imf_pkg::imf_req_s host_req,
  input wire logic [15:0]       host_rdata,
  input wire imf_pkg::imf_req_s sig_req,
  input wire logic [15:0]       sig_rdata,
  input wire logic              h2s_mbox1_word_b_wr,
  input wire logic              s2h_mbox2_word_b_wr,
  input wire logic              s2h_mbox2_word_b_rd,
  input wire logic              host_to_sig_mbox1_irq,
  input wire logic              host_to_sig_mbox2_irq,
  input wire logic              sig_to_host_mbox1_irq,
  input wire logic              sig_to_host_mbox2_irq
);
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);
  property p_b2_set; host_req.wr && host_req.addr == 6'h28 |=> host_to_sig_mbox2_irq; endproperty
  a_b2_set: assert property (p_b2_set) else $error("box2 flag not set");
  property p_b2_clr; sig_req.rd && sig_req.addr == 6'h28 &&
    !(host_req.wr && host_req.addr == 6'h28) |=> !host_to_sig_mbox2_irq; endproperty
  a_b2_clr: assert property (p_b2_clr) else $error("box2 flag not cleared");
  property p_b2_rd; host_req.rd && host_req.addr == 6'h2c |=>
    host_rdata == {15'h0, $past(host_to_sig_mbox2_irq)}; endproperty
  a_b2_rd: assert property (p_b2_rd) else $error("box2 flag read wrong");
  property p_b2_sig; sig_req.rd && sig_req.addr == 6'h2c |=> sig_rdata == 16'h0; endproperty
  a_b2_sig: assert property (p_b2_sig) else $error("core saw host flag");
  property p_b1_rd; host_req.rd && host_req.addr == 6'h18 |=>
    host_rdata == {15'h0, $past(host_to_sig_mbox1_irq)}; endproperty
  a_b1_rd: assert property (p_b1_rd) else $error("box1 flag read wrong");
  property p_s1_rd; sig_req.rd && sig_req.addr == 6'h1c |=>
    sig_rdata == {15'h0, $past(sig_to_host_mbox1_irq)}; endproperty
  a_s1_rd: assert property (p_s1_rd) else $error("core flag read wrong");
  property p_b1_set; h2s_mbox1_word_b_wr |=> host_to_sig_mbox1_irq; endproperty
  a_b1_set: assert property (p_b1_set) else $error("box1 flag not set");
  property p_s2_clr; s2h_mbox2_word_b_rd && !s2h_mbox2_word_b_wr |=> !sig_to_host_mbox2_irq;
  endproperty
  a_s2_clr: assert property (p_s2_clr) else $error("core box2 flag not cleared");
endmodule : imf_mailbox_flags_sva
bind imf_mailbox_flags imf_mailbox_flags_sva u_sva (.*);
`default_nettype wire

// ===== sim/imf_far_side.sv
// Far-side model: mailbox 1 and core-to-host word logic
// Turns register requests into word b event pulses
`default_nettype none
module imf_far_side
  import imf_pkg::*;
(
  input  wire imf_pkg::imf_req_s h,
  input  wire imf_pkg::imf_req_s s,
  output logic [5:0]             ev
);
  timeunit 1ns;
  timeprecision 100ps;
  assign ev[1:0] = {s.rd && s.addr == 6'h04, h.wr && h.addr == 6'h04};
  assign ev[3:2] = {h.rd && h.addr == 6'h0c, s.wr && s.addr == 6'h0c};
  assign ev[5:4] = {h.rd && h.addr == 6'h14, s.wr && s.addr == 6'h14};
endmodule : imf_far_side
`default_nettype wire

// ===== sim/imf_mailbox_flags_test.sv
// Self-checking bench for the mailbox flag block
// Far side from imf_far_side; checker bound to dut
`default_nettype none
module imf_mailbox_flags_test;
  import imf_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  logic mclk = 0, reset = 1;
  imf_req_s hq = '0, sq = '0;
  logic [15:0] hd, sd, v;
  logic [5:0] ev;
  logic [4:0] q;
  int n_mismatch = 0, tests_run = 0;
  always #12.5 mclk = ~mclk;
  imf_far_side fs (.h(hq), .s(sq), .ev(ev));
  imf_mailbox_flags dut (.mclk(mclk), .reset(reset), .host_req(hq), .host_rdata(hd),
    .sig_req(sq), .sig_rdata(sd), .h2s_mbox1_word_b_wr(ev[0]), .h2s_mbox1_word_b_rd(ev[1]),
    .s2h_mbox1_word_b_wr(ev[2]), .s2h_mbox1_word_b_rd(ev[3]), .s2h_mbox2_word_b_wr(ev[4]),
    .s2h_mbox2_word_b_rd(ev[5]), .host_to_sig_mbox1_irq(q[0]), .host_to_sig_mbox2_irq(q[1]),
    .sig_to_host_mbox1_irq(q[2]), .sig_to_host_mbox2_irq(q[3]), .irq(q[4]));
  task automatic chk(input logic [15:0] g, e);
    tests_run++;
    if (g !== e) begin
      n_mismatch++;
      $display("ERROR %0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  task automatic op(input bit s, w, input logic [5:0] a, input logic [15:0] d);
    if (s) sq <= '{a, d, w, !w};
    else hq <= '{a, d, w, !w};
    @(posedge mclk);
    hq <= '0;
    sq <= '0;
    #1 v = s ? sd : hd;
    @(posedge mclk);
  endtask : op
  task automatic rd(input bit s, input logic [5:0] a, input logic [15:0] e);
    op(s, 0, a, 16'h0);
    chk(v, e);
  endtask : rd
  task automatic t_reset;
    rd(0, 6'h18, 16'h0);
    rd(0, 6'h2c, 16'h0);
    rd(0, 6'h24, 16'h0);
    rd(1, 6'h20, 16'h0);
  endtask : t_reset
  task automatic t_box2;
    op(0, 1, 6'h24, 16'ha5c3);
    op(1, 1, 6'h24, 16'h0001);
    rd(1, 6'h24, 16'ha5c3);
    op(0, 1, 6'h28, 16'h5a3c);
    chk(16'(q[1]), 16'h1);
    rd(0, 6'h2c, 16'h1);
    rd(1, 6'h2c, 16'h0);
    rd(1, 6'h28, 16'h5a3c);
    rd(0, 6'h2c, 16'h0);
  endtask : t_box2
  task automatic t_box1;
    op(0, 1, 6'h34, 16'h000f);
    op(0, 1, 6'h04, 16'h1111);
    chk(16'(q[4]), 16'h1);
    rd(0, 6'h18, 16'h1);
    rd(0, 6'h30, 16'h0003);
    chk(16'(q[4]), 16'h0);
    rd(1, 6'h04, 16'h0);
    rd(0, 6'h18, 16'h0);
    op(1, 1, 6'h0c, 16'h2);
    op(1, 1, 6'h14, 16'h3);
    rd(1, 6'h1c, 16'h1);
    rd(0, 6'h1c, 16'h0);
    rd(0, 6'h14, 16'h0);
    rd(1, 6'h20, 16'h0);
    rd(0, 6'h3c, 16'h0);
  endtask : t_box1
  task automatic test_done;
    if (n_mismatch == 0 && tests_run > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : test_done
  initial begin
    repeat (10) @(posedge mclk);
    reset <= 0;
    @(posedge mclk);
    t_reset;
    t_box2;
    t_box1;
    test_done;
  end
  initial begin
    #20us;
    n_mismatch++;
    test_done;
  end
endmodule : imf_mailbox_flags_test
`default_nettype wire
